// ==== hdl/otp_array.sv ====
// One-time-programmable byte array, erased to all ones.
// Contents are nonvolatile in intent, so the block reset leaves them alone.
`timescale 1ns/1ps
`include "otp_field_map.svh"

module otp_array
   import otp_pkg::*;
#(
   parameter int DEPTH = `OTP_FIELD_BYTES
)(
   // Clock
   input  wire logic clk_i,
   // Core carrier
   otp_core_if.mem   core
);

   logic [7:0] mem [DEPTH];

   // Erased state of the field
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = `OTP_ERASED_BYTE;
      end
   end

   // Programming can only clear bits
   always_ff @(posedge clk_i) begin
      if (core.mem_prog) begin
         mem[core.mem_addr] <= mem[core.mem_addr] & core.mem_wdata;
      end
   end

   assign core.mem_rdata = mem[core.mem_addr];

endmodule

// ==== hdl/otp_core_if.sv ====
// Carrier between the command sequencer, the CRC engine and the array.
// All members are synchronous to the one block clock.
`timescale 1ns/1ps
`include "otp_field_map.svh"

interface otp_core_if;
   // CRC engine
   logic                       crc_clear;
   logic                       crc_seed_en;
   logic [7:0]                 crc_seed;
   logic                       crc_shift;
   logic                       crc_bit;
   logic [7:0]                 crc_value;
   // Storage array
   logic [`OTP_FIELD_AW-1:0]   mem_addr;
   logic                       mem_prog;
   logic [7:0]                 mem_wdata;
   logic [7:0]                 mem_rdata;

   modport ctl (
      output crc_clear, crc_seed_en, crc_seed, crc_shift, crc_bit,
      output mem_addr, mem_prog, mem_wdata,
      input  crc_value, mem_rdata
   );
   modport crc (
      input  crc_clear, crc_seed_en, crc_seed, crc_shift, crc_bit,
      output crc_value
   );
   modport mem (
      input  mem_addr, mem_prog, mem_wdata,
      output mem_rdata
   );
endinterface

// ==== hdl/otp_crc8.sv ====
// Bit-serial CRC-8 engine with clear and seed load.
// Assumes at most one of clear, seed and shift per cycle matters; clear wins.
`timescale 1ns/1ps
`include "otp_field_map.svh"

module otp_crc8
   import otp_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // Core carrier
   otp_core_if.crc   core
);

   logic [7:0] crc_reg;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         crc_reg <= `OTP_CRC_SEED;
      end else if (core.crc_clear) begin
         crc_reg <= `OTP_CRC_SEED;
      end else if (core.crc_seed_en) begin
         crc_reg <= core.crc_seed;
      end else if (core.crc_shift) begin
         crc_reg <= otp_crc8_step(crc_reg, core.crc_bit);
      end
   end

   assign core.crc_value = crc_reg;

endmodule

// ==== hdl/otp_field_access.sv ====
// Command sequencer of the one-time-programmable memory field.
// Assumes a slot engine that turns bus timing into one-cycle strobes:
// bus reset, function start, write slot with bit, read slot, and the
// detected high-voltage programming pulse.
//
// Operation
// - Field is four 32-byte pages at 0x00-0x7F; 0x0080 upward is reserved.
// - Unprogrammed bits read back as one.
// - Programming only clears bits; nothing sets a cleared bit again.
// - Bytes are programmed one at a time, each on its programming pulse.
// - A page whose status lock bit is cleared refuses programming.
// - Read commands take command, then address low byte, then high byte.
// - Eight slots after the address return CRC of command and address.
// - Sequential read streams to end of page 3, then data CRC.
// - Bus reset before page 3 end drops the trailing data CRC.
// - Paged read streams to page end, then CRC of bytes read.
// - After each page CRC the next page follows, through page 3.
// - First write CRC covers command, both address bytes and data byte.
// - Programming pulse writes data at the full target address.
// - After each pulse eight slots return stored byte, LSB first.
// - Continuation increments address, seeds CRC with new low address byte.
// - Write may continue to end of field with the same byte cycle.
// - Bus reset after a pulse ends the write, programmed bytes kept.
`timescale 1ns/1ps
`include "otp_field_map.svh"

module otp_field_access
   import otp_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   // Slot engine strobes
   input  wire logic                        bus_reset_i,
   input  wire logic                        func_start_i,
   input  wire logic                        wr_slot_i,
   input  wire logic                        wr_bit_i,
   input  wire logic                        rd_slot_i,
   input  wire logic                        prog_pulse_i,
   // Status field lock bits, cleared means locked
   input  wire logic [`OTP_PAGE_COUNT-1:0]  page_lock_bits_i,
   // Read slot answer
   output logic                             rd_bit_o,
   output logic                             rd_valid_o,
   // Status
   output logic                             prog_done_o,
   output logic                             busy_o
);

   otp_core_if core ();

   otp_crc8 u_crc (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .core      (core.crc)
   );

   otp_array #(
      .DEPTH (`OTP_FIELD_BYTES)
   ) u_array (
      .clk_i (clk_i),
      .core  (core.mem)
   );

   // Address lies inside the data field
   function automatic logic in_field(input logic [15:0] addr);
      in_field = (addr[15:`OTP_FIELD_AW] == `OTP_RESERVED_HI);
   endfunction

   // Address is the last byte of its page
   function automatic logic page_end(input logic [15:0] addr);
      page_end = (addr[`OTP_PAGE_LSB-1:0] == `OTP_PAGE_LAST);
   endfunction

   // Phase takes bytes from the master
   function automatic logic is_rx(input otp_state_type s);
      is_rx = (s == OTP_CMD) || (s == OTP_ADDR_LO) ||
              (s == OTP_ADDR_HI) || (s == OTP_WR_DATA);
   endfunction

   // Phase answers read slots
   function automatic logic is_tx(input otp_state_type s);
      is_tx = (s == OTP_CMD_CRC) || (s == OTP_RD_DATA) ||
              (s == OTP_RD_CRC) || (s == OTP_WR_VERIFY);
   endfunction

   otp_state_type state_reg;
   otp_state_type state_next;
   logic [7:0]    cmd_reg;
   logic [15:0]   addr_reg;
   logic [15:0]   addr_inc;
   logic [7:0]    rx_reg;
   logic [7:0]    rx_byte;
   logic [7:0]    tx_reg;
   logic [2:0]    bit_cnt_reg;
   logic          load_reg;
   logic          rx_state;
   logic          tx_state;
   logic          wr_take;
   logic          rd_take;
   logic          rx_full;
   logic          tx_done;
   logic          is_write;
   logic          prog_en;
   logic [7:0]    field_byte;

   // Phase classification
   assign rx_state = is_rx(state_reg);
   assign tx_state = is_tx(state_reg);

   assign wr_take  = wr_slot_i && rx_state && !bus_reset_i;
   assign rd_take  = rd_slot_i && tx_state && !load_reg && !bus_reset_i;
   assign rx_full  = wr_take && (bit_cnt_reg == `OTP_BYTE_LAST);
   assign tx_done  = rd_take && (bit_cnt_reg == `OTP_BYTE_LAST);
   assign rx_byte  = {wr_bit_i, rx_reg[7:1]};
   assign is_write = (cmd_reg == `OTP_CMD_WRITE);
   assign addr_inc = addr_reg + `OTP_ADDR_ONE;

   // Reserved addresses read as erased
   assign field_byte = in_field(addr_reg) ? core.mem_rdata : `OTP_ERASED_BYTE;

   // Program only inside the field and on an unlocked page
   assign prog_en = (state_reg == OTP_WR_PROG) && prog_pulse_i && !bus_reset_i &&
                    in_field(addr_reg) &&
                    page_lock_bits_i[addr_reg[`OTP_PAGE_MSB:`OTP_PAGE_LSB]];

   // Next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         OTP_IDLE: begin
            if (func_start_i) begin
               state_next = OTP_CMD;
            end
         end
         OTP_CMD: begin
            if (rx_full) begin
               if (rx_byte == `OTP_CMD_READ_SEQ || rx_byte == `OTP_CMD_READ_PAGE ||
                   rx_byte == `OTP_CMD_WRITE) begin
                  state_next = OTP_ADDR_LO;
               end else begin
                  state_next = OTP_DONE;
               end
            end
         end
         OTP_ADDR_LO: begin
            if (rx_full) begin
               state_next = OTP_ADDR_HI;
            end
         end
         OTP_ADDR_HI: begin
            if (rx_full) begin
               state_next = is_write ? OTP_WR_DATA : OTP_CMD_CRC;
            end
         end
         OTP_WR_DATA: begin
            if (rx_full) begin
               state_next = OTP_CMD_CRC;
            end
         end
         OTP_CMD_CRC: begin
            if (tx_done) begin
               if (is_write) begin
                  state_next = OTP_WR_PROG;
               end else if (in_field(addr_reg)) begin
                  state_next = OTP_RD_DATA;
               end else begin
                  state_next = OTP_DONE;
               end
            end
         end
         OTP_RD_DATA: begin
            if (tx_done) begin
               if (!in_field(addr_inc)) begin
                  state_next = OTP_RD_CRC;
               end else if (cmd_reg == `OTP_CMD_READ_PAGE && page_end(addr_reg)) begin
                  state_next = OTP_RD_CRC;
               end
            end
         end
         OTP_RD_CRC: begin
            if (tx_done) begin
               state_next = in_field(addr_reg) ? OTP_RD_DATA : OTP_DONE;
            end
         end
         OTP_WR_PROG: begin
            if (prog_pulse_i) begin
               state_next = OTP_WR_VERIFY;
            end
         end
         OTP_WR_VERIFY: begin
            if (tx_done) begin
               state_next = in_field(addr_inc) ? OTP_WR_DATA : OTP_DONE;
            end
         end
         OTP_DONE: begin
            state_next = OTP_DONE;
         end
         default: begin
            state_next = OTP_IDLE;
         end
      endcase
      if (bus_reset_i) begin
         state_next = OTP_IDLE;
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= OTP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Bit counter, restarted on every phase change
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_cnt_reg <= `OTP_CNT_RESET;
      end else if (state_next != state_reg) begin
         bit_cnt_reg <= `OTP_CNT_RESET;
      end else if (wr_take || rd_take) begin
         bit_cnt_reg <= bit_cnt_reg + `OTP_CNT_ONE;
      end
   end

   // Receive shifter, LSB first
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_reg <= `OTP_BYTE_RESET;
      end else if (wr_take) begin
         rx_reg <= rx_byte;
      end
   end

   // Command byte
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_reg <= `OTP_BYTE_RESET;
      end else if (state_reg == OTP_CMD && rx_full) begin
         cmd_reg <= rx_byte;
      end
   end

   // Target address pointer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_reg <= `OTP_ADDR_RESET;
      end else if (state_reg == OTP_ADDR_LO && rx_full) begin
         addr_reg[7:0] <= rx_byte;
      end else if (state_reg == OTP_ADDR_HI && rx_full) begin
         addr_reg[15:8] <= rx_byte;
      end else if ((state_reg == OTP_RD_DATA || state_reg == OTP_WR_VERIFY) && tx_done) begin
         addr_reg <= addr_inc;
      end
   end

   // Transmit byte load, one cycle after entering a byte
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         load_reg <= 1'b0;
      end else begin
         load_reg <= is_tx(state_next) && ((state_next != state_reg) || tx_done);
      end
   end

   // Transmit shifter
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_reg <= `OTP_ERASED_BYTE;
      end else if (load_reg) begin
         if (state_reg == OTP_CMD_CRC || state_reg == OTP_RD_CRC) begin
            tx_reg <= core.crc_value;
         end else begin
            tx_reg <= field_byte;
         end
      end else if (rd_take) begin
         tx_reg <= {1'b1, tx_reg[7:1]};
      end
   end

   // CRC engine control
   always_comb begin
      core.crc_clear   = func_start_i && (state_reg == OTP_IDLE);
      core.crc_seed_en = 1'b0;
      core.crc_seed    = addr_inc[7:0];
      core.crc_shift   = 1'b0;
      core.crc_bit     = wr_bit_i;
      if (rx_state && wr_take) begin
         core.crc_shift = 1'b1;
      end else if (state_reg == OTP_RD_DATA && rd_take) begin
         core.crc_shift = 1'b1;
         core.crc_bit   = tx_reg[0];
      end
      if ((state_reg == OTP_CMD_CRC && !is_write && tx_done) ||
          (state_reg == OTP_RD_CRC && tx_done)) begin
         core.crc_clear = 1'b1;
      end
      if (state_reg == OTP_WR_VERIFY && tx_done) begin
         core.crc_seed_en = 1'b1;
      end
   end

   // Array access
   assign core.mem_addr  = addr_reg[`OTP_FIELD_AW-1:0];
   assign core.mem_prog  = prog_en;
   assign core.mem_wdata = rx_reg;

   // Read slot answer, ones outside transmit phases
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_bit_o <= 1'b1;
      end else begin
         rd_bit_o <= rd_take ? tx_reg[0] : 1'b1;
      end
   end

   // Read slot acknowledge
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_slot_i;
      end
   end

   // Programming strobe
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prog_done_o <= 1'b0;
      end else begin
         prog_done_o <= prog_en;
      end
   end

   // Command activity
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (state_next != OTP_IDLE) && (state_next != OTP_DONE);
      end
   end

endmodule

// ==== hdl/otp_field_map.svh ====
// Constants of the one-time-programmable memory field access block.
// Included by the package and by every design file that needs a figure.
`ifndef OTP_FIELD_MAP_SVH
`define OTP_FIELD_MAP_SVH

// Function command codes
`define OTP_CMD_READ_SEQ   8'hF0
`define OTP_CMD_READ_PAGE  8'hC3
`define OTP_CMD_WRITE      8'h0F

// Field layout
`define OTP_FIELD_BYTES    128
`define OTP_FIELD_AW       7
`define OTP_PAGE_LAST      5'h1F
`define OTP_PAGE_MSB       6
`define OTP_PAGE_LSB       5
`define OTP_PAGE_COUNT     4
`define OTP_RESERVED_HI    9'h000

// Values
`define OTP_ERASED_BYTE    8'hFF
`define OTP_CRC_POLY       8'h8C
`define OTP_CRC_SEED       8'h00
`define OTP_BYTE_LAST      3'h7
`define OTP_ADDR_ONE       16'h0001
`define OTP_ADDR_RESET     16'h0000
`define OTP_BYTE_RESET     8'h00
`define OTP_CNT_RESET      3'h0
`define OTP_CNT_ONE        3'h1

`endif

// ==== hdl/otp_pkg.sv ====
// Types and shared arithmetic of the memory field access block.
// Assumes the constant header is on the include path.
`include "otp_field_map.svh"

package otp_pkg;

   typedef enum logic [3:0] {
      OTP_IDLE,
      OTP_CMD,
      OTP_ADDR_LO,
      OTP_ADDR_HI,
      OTP_WR_DATA,
      OTP_CMD_CRC,
      OTP_RD_DATA,
      OTP_RD_CRC,
      OTP_WR_PROG,
      OTP_WR_VERIFY,
      OTP_DONE
   } otp_state_type;

   // One bit of the reflected CRC-8, x^8+x^5+x^4+1
   function automatic logic [7:0] otp_crc8_step(input logic [7:0] crc, input logic din);
      logic fb;
      fb = crc[0] ^ din;
      otp_crc8_step = {1'b0, crc[7:1]} ^ (fb ? `OTP_CRC_POLY : 8'h00);
   endfunction

endpackage

// ==== test/otp_field_access_assertions.sv ====
// Port checks on the memory field access sequencer.
// Assumes slot strobes come at least two cycles apart.
`timescale 1ns/1ps
`include "otp_field_map.svh"

module otp_field_access_assertions (
   // Clock and reset
   input wire logic                       clk_i,
   input wire logic                       reset_n_i,
   // Slot strobes
   input wire logic                       bus_reset_i,
   input wire logic                       func_start_i,
   input wire logic                       wr_slot_i,
   input wire logic                       wr_bit_i,
   input wire logic                       rd_slot_i,
   input wire logic                       prog_pulse_i,
   input wire logic [`OTP_PAGE_COUNT-1:0] page_lock_bits_i,
   // Answers
   input wire logic                       rd_bit_o,
   input wire logic                       rd_valid_o,
   input wire logic                       prog_done_o,
   input wire logic                       busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_valid_follow;
      rd_slot_i |=> rd_valid_o;
   endproperty
   a_valid_follow: assert property (p_valid_follow)
      else $error("read slot not answered");
   property p_valid_cause;
      rd_valid_o |-> $past(rd_slot_i);
   endproperty
   a_valid_cause: assert property (p_valid_cause)
      else $error("answer without read slot");
   property p_idle_ones;
      rd_valid_o && !$past(busy_o) |-> rd_bit_o;
   endproperty
   a_idle_ones: assert property (p_idle_ones)
      else $error("idle read slot not one");
   property p_stay_idle;
      !busy_o && !func_start_i && !$past(func_start_i) |=> !busy_o;
   endproperty
   a_stay_idle: assert property (p_stay_idle)
      else $error("busy without function start");
   property p_prog_cause;
      prog_done_o |-> $past(prog_pulse_i) && $past(busy_o);
   endproperty
   a_prog_cause: assert property (p_prog_cause)
      else $error("programming without pulse");
   property p_prog_idle;
      prog_pulse_i && !busy_o |=> !prog_done_o;
   endproperty
   a_prog_idle: assert property (p_prog_idle)
      else $error("pulse programmed while idle");
   property p_bus_reset;
      bus_reset_i |=> !busy_o [*2];
   endproperty
   a_bus_reset: assert property (p_bus_reset)
      else $error("bus reset left command running");
   property p_prog_once;
      $rose(prog_done_o) |=> !prog_done_o;
   endproperty
   a_prog_once: assert property (p_prog_once)
      else $error("programming done longer than one cycle");
endmodule

bind otp_field_access otp_field_access_assertions u_chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_reset_i(bus_reset_i),
   .func_start_i(func_start_i), .wr_slot_i(wr_slot_i), .wr_bit_i(wr_bit_i),
   .rd_slot_i(rd_slot_i), .prog_pulse_i(prog_pulse_i),
   .page_lock_bits_i(page_lock_bits_i), .rd_bit_o(rd_bit_o),
   .rd_valid_o(rd_valid_o), .prog_done_o(prog_done_o), .busy_o(busy_o)
);

// ==== test/otp_master_model.sv ====
// Bus master model issuing slot strobes to the sequencer.
// Assumes one clock; strobes last one cycle, two cycles apart.
`timescale 1ns/1ps

module otp_master_model (
   // Clock
   input  wire logic clk_i,
   // Device answers
   input  wire logic rd_bit_i,
   input  wire logic rd_valid_i,
   input  wire logic prog_done_i,
   // Slot strobes
   output logic      bus_reset_o,
   output logic      func_start_o,
   output logic      wr_slot_o,
   output logic      wr_bit_o,
   output logic      rd_slot_o,
   output logic      prog_pulse_o
);
   initial begin
      bus_reset_o = 1'b0;
      func_start_o = 1'b0;
      wr_slot_o = 1'b0;
      wr_bit_o = 1'b0;
      rd_slot_o = 1'b0;
      prog_pulse_o = 1'b0;
   end

   // Restart after a bad CRC or to end a command
   task automatic bus_reset();
      @(posedge clk_i) bus_reset_o <= 1'b1;
      @(posedge clk_i) bus_reset_o <= 1'b0;
   endtask

   task automatic start_cmd();
      @(posedge clk_i) func_start_o <= 1'b1;
      @(posedge clk_i) func_start_o <= 1'b0;
   endtask

   // Byte out, LSB first; bit line inverted once released
   task automatic wr_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         wr_slot_o <= 1'b1;
         wr_bit_o <= b[i];
         @(posedge clk_i);
         wr_slot_o <= 1'b0;
         wr_bit_o <= ~b[i];
      end
   endtask

   // Eight read slots, LSB first; missing answer gives unknown
   task automatic rd_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i) rd_slot_o <= 1'b1;
         @(posedge clk_i) rd_slot_o <= 1'b0;
         @(negedge clk_i);
         b[i] = (rd_valid_i === 1'b1) ? rd_bit_i : 1'bx;
      end
   endtask

   // One short pulse per byte, only after the CRC read
   task automatic prog(output logic done);
      @(posedge clk_i) prog_pulse_o <= 1'b1;
      @(posedge clk_i) prog_pulse_o <= 1'b0;
      @(negedge clk_i);
      done = prog_done_i;
   endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench of the memory field access sequencer.
// Assumes an erased array at start and the master model as driver.
`timescale 1ns/1ps
`include "otp_field_map.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_top;
   logic                       clk_i;
   logic                       reset_n_i;
   logic                       bus_reset_i, func_start_i, wr_slot_i, wr_bit_i;
   logic                       rd_slot_i, prog_pulse_i;
   logic [`OTP_PAGE_COUNT-1:0] page_lock_bits_i;
   logic                       rd_bit_o, rd_valid_o, prog_done_o, busy_o;
   logic [7:0]                 shadow [0:127];
   int                         n_tests;
   int                         fail_count;

   otp_field_access dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_reset_i(bus_reset_i),
      .func_start_i(func_start_i), .wr_slot_i(wr_slot_i), .wr_bit_i(wr_bit_i),
      .rd_slot_i(rd_slot_i), .prog_pulse_i(prog_pulse_i),
      .page_lock_bits_i(page_lock_bits_i), .rd_bit_o(rd_bit_o),
      .rd_valid_o(rd_valid_o), .prog_done_o(prog_done_o), .busy_o(busy_o));
   otp_master_model mst (.clk_i(clk_i), .rd_bit_i(rd_bit_o), .rd_valid_i(rd_valid_o),
      .prog_done_i(prog_done_o), .bus_reset_o(bus_reset_i), .func_start_o(func_start_i),
      .wr_slot_o(wr_slot_i), .wr_bit_o(wr_bit_i), .rd_slot_o(rd_slot_i),
      .prog_pulse_o(prog_pulse_i));

   function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      logic       fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[0] ^ d[i];
         r = {1'b0, r[7:1]} ^ (fb ? `OTP_CRC_POLY : 8'h00);
      end
      return r;
   endfunction

   task automatic head(input logic [7:0] cmd, input logic [15:0] a, output logic [7:0] c);
      mst.bus_reset();
      mst.start_cmd();
      mst.wr_byte(cmd);
      mst.wr_byte(a[7:0]);
      mst.wr_byte(a[15:8]);
      c = crc_byte(crc_byte(crc_byte(8'h00, cmd), a[7:0]), a[15:8]);
   endtask

   task automatic rd_head(input logic [7:0] cmd, input logic [15:0] a);
      logic [7:0] c;
      logic [7:0] got;
      head(cmd, a, c);
      mst.rd_byte(got);
      `CHK("command crc", c, got)
   endtask

   task automatic w_byte(input logic [7:0] c0, input logic [7:0] d, input int a,
                         input logic ok);
      logic [7:0] got;
      logic       done;
      mst.wr_byte(d);
      mst.rd_byte(got);
      `CHK("write crc", crc_byte(c0, d), got)
      mst.prog(done);
      `CHK("prog done", ok, done)
      if (ok) shadow[a] = shadow[a] & d;
      mst.rd_byte(got);
      `CHK("verify byte", (a < 128) ? shadow[a] : 8'hFF, got)
   endtask

   task automatic t_write;
      logic [7:0] c;
      logic [7:0] got;
      head(`OTP_CMD_WRITE, 16'h0005, c);
      w_byte(c, 8'h3C, 5, 1'b1);
      w_byte(8'h06, 8'hF0, 6, 1'b1);
      rd_head(`OTP_CMD_READ_SEQ, 16'h0005);
      mst.rd_byte(got);
      `CHK("kept byte", 8'h3C, got)
      mst.rd_byte(got);
      `CHK("kept byte", 8'hF0, got)
      head(`OTP_CMD_WRITE, 16'h0005, c);
      w_byte(c, 8'hC3, 5, 1'b1);
      w_byte(8'h06, 8'hFF, 6, 1'b1);
      $display("test write done");
   endtask

   task automatic t_limits;
      logic [7:0] c;
      logic [7:0] got;
      logic       done;
      page_lock_bits_i <= 4'hD;
      head(`OTP_CMD_WRITE, 16'h0020, c);
      w_byte(c, 8'h00, 32, 1'b0);
      head(`OTP_CMD_WRITE, 16'h007F, c);
      w_byte(c, 8'hA5, 127, 1'b1);
      mst.wr_byte(8'h00);
      mst.rd_byte(got);
      `CHK("past field end", 8'hFF, got)
      mst.prog(done);
      `CHK("late pulse", 1'b0, done)
      head(`OTP_CMD_WRITE, 16'h0080, c);
      w_byte(c, 8'h00, 128, 1'b0);
      rd_head(`OTP_CMD_READ_SEQ, 16'h0100);
      mst.rd_byte(got);
      `CHK("reserved read", 8'hFF, got)
      head(8'h99, 16'h0000, c);
      mst.rd_byte(got);
      `CHK("unknown command", 8'hFF, got)
      `CHK("unknown busy", 1'b0, busy_o)
      $display("test limits done");
   endtask

   task automatic t_read_seq;
      logic [7:0] c;
      logic [7:0] got;
      c = 8'h00;
      rd_head(`OTP_CMD_READ_SEQ, 16'h007E);
      for (int a = 126; a < 128; a++) begin
         mst.rd_byte(got);
         `CHK("seq data", shadow[a], got)
         c = crc_byte(c, shadow[a]);
      end
      mst.rd_byte(got);
      `CHK("seq crc", c, got)
      mst.rd_byte(got);
      `CHK("seq tail", 8'hFF, got)
      `CHK("seq busy", 1'b0, busy_o)
      rd_head(`OTP_CMD_READ_SEQ, 16'h0010);
      mst.rd_byte(got);
      mst.bus_reset();
      mst.rd_byte(got);
      `CHK("aborted read", 8'hFF, got)
      $display("test read_seq done");
   endtask

   task automatic t_page_read;
      logic [7:0] c;
      logic [7:0] got;
      c = 8'h00;
      rd_head(`OTP_CMD_READ_PAGE, 16'h001E);
      for (int a = 30; a < 128; a++) begin
         mst.rd_byte(got);
         `CHK("page data", shadow[a], got)
         c = crc_byte(c, shadow[a]);
         if (a[4:0] == 5'h1F) begin
            mst.rd_byte(got);
            `CHK("page crc", c, got)
            c = 8'h00;
         end
      end
      mst.rd_byte(got);
      `CHK("page tail", 8'hFF, got)
      $display("test page_read done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial begin
      #200000;
      fail_count++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      n_tests = 0;
      fail_count = 0;
      reset_n_i = 1'b0;
      page_lock_bits_i = 4'hF;
      for (int i = 0; i < 128; i++) shadow[i] = `OTP_ERASED_BYTE;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_write();
      t_limits();
      t_read_seq();
      t_page_read();
      wrap_up();
   end
endmodule
